// ### core/tsr_pkg.sv
// temperature sensor register file: constants, register map and carrier types
// assumes: byte-wide requests from a two-wire slave engine, one conversion path outside
package tsr_pkg;

    // command pointer locations
    localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
    localparam logic [7:0] ADDR_REMOTE_INT = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_CONFIG_RD = 8'h03;
    localparam logic [7:0] ADDR_RATE_RD = 8'h04;
    localparam logic [7:0] ADDR_LHIGH_RD = 8'h05;
    localparam logic [7:0] ADDR_LLOW_RD = 8'h06;
    localparam logic [7:0] ADDR_RHIGH_RD = 8'h07;
    localparam logic [7:0] ADDR_RLOW_RD = 8'h08;
    localparam logic [7:0] ADDR_CONFIG_WR = 8'h09;
    localparam logic [7:0] ADDR_RATE_WR = 8'h0A;
    localparam logic [7:0] ADDR_LHIGH_WR = 8'h0B;
    localparam logic [7:0] ADDR_LLOW_WR = 8'h0C;
    localparam logic [7:0] ADDR_RHIGH_WR = 8'h0D;
    localparam logic [7:0] ADDR_RLOW_WR = 8'h0E;
    localparam logic [7:0] ADDR_ONE_SHOT = 8'h0F;
    localparam logic [7:0] ADDR_REMOTE_FRAC = 8'h10;
    localparam logic [7:0] ADDR_OFS_INT = 8'h11;
    localparam logic [7:0] ADDR_OFS_FRAC = 8'h12;
    localparam logic [7:0] ADDR_RHIGH_FRAC = 8'h13;
    localparam logic [7:0] ADDR_RLOW_FRAC = 8'h14;
    localparam logic [7:0] ADDR_RCRIT = 8'h19;
    localparam logic [7:0] ADDR_LCRIT = 8'h20;
    localparam logic [7:0] ADDR_HYST = 8'h21;
    localparam logic [7:0] ADDR_FILTER = 8'hBF;
    localparam logic [7:0] ADDR_MAKER = 8'hFE;
    localparam logic [7:0] ADDR_REVISION = 8'hFF;

    // power-on values
    localparam logic [7:0] RST_POINTER = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_RATE = 8'h08;
    localparam logic [7:0] RST_HIGH = 8'h46;
    localparam logic [7:0] RST_LOW = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_RCRIT = 8'h6E;
    localparam logic [7:0] RST_LCRIT = 8'h55;
    localparam logic [7:0] RST_LCRIT_ALT = 8'h69;
    localparam logic [7:0] RST_HYST = 8'h0A;
    localparam logic [7:0] RST_FILTER = 8'h00;

    // field layout
    localparam int CFG_STANDBY_BIT = 6;
    localparam int CFG_FQ_BIT = 0;
    localparam int FILT_LVL_LSB = 1;
    localparam logic [7:0] MASK_CONFIG = 8'hD5;
    localparam logic [7:0] MASK_FILTER = 8'h07;
    localparam logic [7:0] MASK_HYST = 8'h1F;
    localparam logic [7:0] MASK_FRAC = 8'hE0;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    localparam int ST_BUSY = 7;
    localparam int ST_LHIGH = 6;
    localparam int ST_LLOW = 5;
    localparam int ST_RHIGH = 4;
    localparam int ST_RLOW = 3;
    localparam int ST_OPEN = 2;
    localparam int ST_RCRIT = 1;
    localparam int ST_LCRIT = 0;

    // conversion timing and data ranges
    localparam logic [1:0] FQ_DEPTH = 2'h3;
    localparam logic [7:0] RATE_MAX_CODE = 8'h09;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned SLOWEST_PERIOD_MS = 16_000;
    localparam int unsigned SLOWEST_PERIOD_CYC = SLOWEST_PERIOD_MS * (CLK_HZ / 1000);
    localparam logic signed [13:0] REMOTE_MAX = 14'sh03FF;
    localparam logic signed [13:0] REMOTE_MIN = -14'sh0400;
    localparam logic signed [10:0] REMOTE_OPEN = 11'sh3F8;
    localparam logic signed [9:0] LOCAL_MAX = 10'sh07F;
    localparam logic signed [9:0] LOCAL_MIN = -10'sh080;

    // writable setting bytes, one slot each
    localparam int NUM_SET = 14;
    localparam int SI_LCRIT = 11;
    localparam logic [7:0] SET_WR_ADDR [NUM_SET] = '{ADDR_CONFIG_WR, ADDR_RATE_WR,
        ADDR_LHIGH_WR, ADDR_LLOW_WR, ADDR_RHIGH_WR, ADDR_RLOW_WR, ADDR_OFS_INT, ADDR_OFS_FRAC,
        ADDR_RHIGH_FRAC, ADDR_RLOW_FRAC, ADDR_RCRIT, ADDR_LCRIT, ADDR_HYST, ADDR_FILTER};
    localparam logic [7:0] SET_RD_ADDR [NUM_SET] = '{ADDR_CONFIG_RD, ADDR_RATE_RD,
        ADDR_LHIGH_RD, ADDR_LLOW_RD, ADDR_RHIGH_RD, ADDR_RLOW_RD, ADDR_OFS_INT, ADDR_OFS_FRAC,
        ADDR_RHIGH_FRAC, ADDR_RLOW_FRAC, ADDR_RCRIT, ADDR_LCRIT, ADDR_HYST, ADDR_FILTER};
    localparam logic [7:0] SET_RESET [NUM_SET] = '{RST_CONFIG, RST_RATE, RST_HIGH, RST_LOW,
        RST_HIGH, RST_LOW, RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO, RST_RCRIT, RST_LCRIT,
        RST_HYST, RST_FILTER};
    localparam logic [7:0] SET_MASK [NUM_SET] = '{MASK_CONFIG, MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_FULL, MASK_FRAC, MASK_FRAC, MASK_FRAC, MASK_FULL, MASK_FULL,
        MASK_HYST, MASK_FILTER};

    typedef enum logic [1:0] {TSR_REQ_CMD, TSR_REQ_WR, TSR_REQ_RD} tsr_req_kind_t;

    typedef struct packed {
        tsr_req_kind_t kind;
        logic [7:0] data;
    } tsr_req_t;

    typedef struct packed {
        logic signed [9:0] local_raw;
        logic signed [11:0] remote_raw;
        logic diode_open;
    } tsr_meas_t;

    typedef enum {TSR_IDLE, TSR_CONV} tsr_conv_state_t;

endpackage

// ### core/tsr_register_file.sv
// temperature sensor register file with conversion sequencing and limit checks
// assumes: slave engine on clk_link_i hands over one byte request at a time;
// the analog path answers each conv_req_o with one meas_valid_i on clk_sys_i
//
// Function
// - filter code 00 off, 01/10 level1, 11 level2
// - fault queue needs three successive remote violations
// - fault queue off at reset, config bit0 enables
// - one-shot write in standby runs one conversion
// - one-shot data discarded, reads as zero
// - defaults hold until first conversion completes
// - command pointer resets to local temperature
// - status and configuration reset to zero
// - conversion rate resets to code eight
// - setpoints and hysteresis have fixed reset values
// - filter and alert configuration resets zero
// - command byte latched whole as pointer
// - measurement, status, identity locations are read-only
// - config, rate, limits use split addresses
// - offset, fraction, critical, hysteresis, filter share address
// - integer temperatures are signed, one degree
// - remote fraction in bits 7:5, rest zero
// - readings saturate to their documented ranges
// - filter smooths without steady offset
// - identity and revision codes are read-only
// - pointer persists until rewritten
// - reading remote integer freezes fraction byte
// - config bit6 puts device into standby
`timescale 1ns/1ps
`default_nettype none

module tsr_register_file #(
    parameter int unsigned CONV_BASE_CYCLES = tsr_pkg::SLOWEST_PERIOD_CYC,
    parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] DIE_REV = 8'hA3,   // arbitrary value
    parameter bit LCRIT_ALT = 1'b0
) (
    // clocks and reset
    input wire logic clk_sys_i,
    input wire logic clk_link_i,
    input wire logic resetn_i,
    // link side requests, clk_link_i domain
    input wire logic lk_req_valid_i,
    input wire tsr_pkg::tsr_req_t lk_req_i,
    output logic lk_ready_o,
    output logic lk_rd_valid_o,
    output logic [7:0] lk_rd_data_o,
    // measurement path, clk_sys_i domain
    input wire logic meas_valid_i,
    input wire tsr_pkg::tsr_meas_t meas_i,
    output logic conv_req_o,
    output logic [7:0] alarm_status_o
);

    // link domain: hold one request, toggle it across, wait for the answer toggle
    tsr_pkg::tsr_req_t lk_req_reg;
    logic lk_req_tgl_reg;
    logic lk_ready_reg;
    logic lk_rd_valid_reg;
    logic [7:0] lk_rd_data_reg;
    logic lk_ack_s1_reg;
    logic lk_ack_s2_reg;
    logic lk_ack_s3_reg;
    logic sys_ack_tgl_reg;
    logic [7:0] sys_rd_data_reg;

    wire lk_accept = lk_req_valid_i & lk_ready_reg;
    wire lk_ack_ev = lk_ack_s2_reg ^ lk_ack_s3_reg;

    always_ff @(posedge clk_link_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_ack_s1_reg <= 1'b0;
            lk_ack_s2_reg <= 1'b0;
            lk_ack_s3_reg <= 1'b0;
        end else begin
            lk_ack_s1_reg <= sys_ack_tgl_reg;
            lk_ack_s2_reg <= lk_ack_s1_reg;
            lk_ack_s3_reg <= lk_ack_s2_reg;
        end
    end

    always_ff @(posedge clk_link_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_req_reg <= '{kind: tsr_pkg::TSR_REQ_CMD, data: 8'h00};
            lk_req_tgl_reg <= 1'b0;
            lk_ready_reg <= 1'b1;
        end else if (lk_accept) begin
            lk_req_reg <= lk_req_i;
            lk_req_tgl_reg <= ~lk_req_tgl_reg;
            lk_ready_reg <= 1'b0;
        end else if (lk_ack_ev) begin
            lk_ready_reg <= 1'b1;
        end
    end

    // the answer byte is held still by the system side until the next request
    always_ff @(posedge clk_link_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_rd_valid_reg <= 1'b0;
            lk_rd_data_reg <= 8'h00;
        end else begin
            lk_rd_valid_reg <= lk_ack_ev & (lk_req_reg.kind == tsr_pkg::TSR_REQ_RD);
            if (lk_ack_ev) begin
                lk_rd_data_reg <= sys_rd_data_reg;
            end
        end
    end

    assign lk_ready_o = lk_ready_reg;
    assign lk_rd_valid_o = lk_rd_valid_reg;
    assign lk_rd_data_o = lk_rd_data_reg;

    // system domain: catch the request toggle
    logic sys_req_s1_reg;
    logic sys_req_s2_reg;
    logic sys_req_s3_reg;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_req_s1_reg <= 1'b0;
            sys_req_s2_reg <= 1'b0;
            sys_req_s3_reg <= 1'b0;
        end else begin
            sys_req_s1_reg <= lk_req_tgl_reg;
            sys_req_s2_reg <= sys_req_s1_reg;
            sys_req_s3_reg <= sys_req_s2_reg;
        end
    end

    wire req_ev = sys_req_s2_reg ^ sys_req_s3_reg;
    wire ev_cmd = req_ev & (lk_req_reg.kind == tsr_pkg::TSR_REQ_CMD);
    wire ev_wr = req_ev & (lk_req_reg.kind == tsr_pkg::TSR_REQ_WR);
    wire ev_rd = req_ev & (lk_req_reg.kind == tsr_pkg::TSR_REQ_RD);
    wire [7:0] req_data = lk_req_reg.data;

    // command pointer
    logic [7:0] pointer_reg;

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pointer_reg <= tsr_pkg::RST_POINTER;
        end else if (ev_cmd) begin
            pointer_reg <= req_data;
        end
    end

    // setting bytes: only listed write addresses reach them
    logic [7:0] set_reg [tsr_pkg::NUM_SET];
    logic [7:0] set_rd_chain [tsr_pkg::NUM_SET + 1];

    assign set_rd_chain[0] = 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < tsr_pkg::NUM_SET; gi++) begin : g_set
            localparam logic [7:0] RST_VAL = (gi == tsr_pkg::SI_LCRIT && LCRIT_ALT) ?
                tsr_pkg::RST_LCRIT_ALT : tsr_pkg::SET_RESET[gi];
            wire set_we = ev_wr & (pointer_reg == tsr_pkg::SET_WR_ADDR[gi]);
            wire set_hit = pointer_reg == tsr_pkg::SET_RD_ADDR[gi];
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    set_reg[gi] <= RST_VAL;
                end else if (set_we) begin
                    set_reg[gi] <= req_data & tsr_pkg::SET_MASK[gi];
                end
            end
            assign set_rd_chain[gi + 1] = set_rd_chain[gi] | (set_hit ? set_reg[gi] : 8'h00);
        end
    endgenerate

    wire [7:0] cfg_byte = set_reg[0];
    wire [7:0] rate_byte = set_reg[1];
    wire signed [7:0] local_high_limit = set_reg[2];
    wire signed [7:0] local_low_limit = set_reg[3];
    wire signed [7:0] remote_high_limit_int = set_reg[4];
    wire signed [7:0] remote_low_limit_int = set_reg[5];
    wire [7:0] remote_offset_int = set_reg[6];
    wire [7:0] remote_offset_frac = set_reg[7];
    wire [7:0] remote_high_limit_frac = set_reg[8];
    wire [7:0] remote_low_limit_frac = set_reg[9];
    wire signed [7:0] remote_critical_limit = set_reg[10];
    wire signed [7:0] local_critical_limit = set_reg[11];
    wire [7:0] critical_hysteresis = set_reg[12];
    wire [7:0] filter_and_alert_config = set_reg[13];

    wire standby = cfg_byte[tsr_pkg::CFG_STANDBY_BIT];
    wire fq_on = cfg_byte[tsr_pkg::CFG_FQ_BIT];
    wire [1:0] filt_code = filter_and_alert_config[tsr_pkg::FILT_LVL_LSB +: 2];

    // conversion sequencing
    tsr_pkg::tsr_conv_state_t conv_state_reg;
    logic conv_req_reg;
    logic oneshot_pend_reg;
    logic [31:0] timer_reg;

    wire [3:0] rate_code = (rate_byte > tsr_pkg::RATE_MAX_CODE) ?
        tsr_pkg::RATE_MAX_CODE[3:0] : rate_byte[3:0];
    wire [31:0] period_cyc = CONV_BASE_CYCLES >> rate_code;
    wire timer_done = timer_reg >= (period_cyc - 32'h1);
    wire idle = conv_state_reg == tsr_pkg::TSR_IDLE;
    wire oneshot_wr = ev_wr & (pointer_reg == tsr_pkg::ADDR_ONE_SHOT);
    wire conv_start = idle & (standby ? oneshot_pend_reg : timer_done);
    wire conv_done = meas_valid_i & (conv_state_reg == tsr_pkg::TSR_CONV);

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oneshot_pend_reg <= 1'b0;
        end else if (!standby || conv_start) begin
            oneshot_pend_reg <= 1'b0;
        end else if (oneshot_wr && idle) begin
            oneshot_pend_reg <= 1'b1;
        end
    end

    // the timer is held in standby so leaving standby restarts a full period
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            timer_reg <= 32'h0;
        end else if (standby || conv_start) begin
            timer_reg <= 32'h0;
        end else if (!timer_done) begin
            timer_reg <= timer_reg + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            conv_state_reg <= tsr_pkg::TSR_IDLE;
            conv_req_reg <= 1'b0;
        end else begin
            conv_req_reg <= conv_start;
            case (conv_state_reg)
                tsr_pkg::TSR_IDLE: begin
                    if (conv_start) begin
                        conv_state_reg <= tsr_pkg::TSR_CONV;
                    end
                end
                tsr_pkg::TSR_CONV: begin
                    if (meas_valid_i) begin
                        conv_state_reg <= tsr_pkg::TSR_IDLE;
                    end
                end
                default: conv_state_reg <= tsr_pkg::TSR_IDLE;
            endcase
        end
    end

    assign conv_req_o = conv_req_reg;

    // measurement conditioning
    wire signed [9:0] local_in = meas_i.local_raw;
    wire signed [7:0] local_sat = (local_in > tsr_pkg::LOCAL_MAX) ? 8'sh7F :
        (local_in < tsr_pkg::LOCAL_MIN) ? 8'sh80 : local_in[7:0];

    wire signed [13:0] ofs_eighths = {{3{remote_offset_int[7]}}, remote_offset_int,
        remote_offset_frac[7:5]};
    wire signed [13:0] rem_sum = {{2{meas_i.remote_raw[11]}}, meas_i.remote_raw} + ofs_eighths;
    wire signed [13:0] rem_clamp = (rem_sum > tsr_pkg::REMOTE_MAX) ? tsr_pkg::REMOTE_MAX :
        (rem_sum < tsr_pkg::REMOTE_MIN) ? tsr_pkg::REMOTE_MIN : rem_sum;

    // first-order smoothing with four guard bits, rounded back, so no standing bias
    logic signed [14:0] filt_acc_reg;
    logic filt_primed_reg;
    wire signed [14:0] rem_x16 = {rem_clamp[10:0], 4'h0};
    wire signed [15:0] filt_diff = {rem_x16[14], rem_x16} - {filt_acc_reg[14], filt_acc_reg};
    wire signed [15:0] filt_step = (filt_code == 2'b11) ? (filt_diff >>> 2) :
        (filt_diff >>> 1);
    wire filt_bypass = (filt_code == 2'b00) | ~filt_primed_reg | meas_i.diode_open;
    wire signed [15:0] filt_sum = {filt_acc_reg[14], filt_acc_reg} + filt_step;
    wire signed [14:0] filt_next = filt_bypass ? rem_x16 : filt_sum[14:0];
    wire signed [15:0] filt_round = ({filt_next[14], filt_next} + 16'sh0008) >>> 4;
    wire signed [10:0] rem_val = meas_i.diode_open ? tsr_pkg::REMOTE_OPEN : filt_round[10:0];

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            filt_acc_reg <= 15'sh0;
            filt_primed_reg <= 1'b0;
        end else if (conv_done) begin
            filt_acc_reg <= filt_next;
            filt_primed_reg <= 1'b1;
        end
    end

    // limit comparisons, all signed; remote in eighths of a degree, local in whole degrees
    wire signed [10:0] rhigh_e = {remote_high_limit_int, remote_high_limit_frac[7:5]};
    wire signed [10:0] rlow_e = {remote_low_limit_int, remote_low_limit_frac[7:5]};
    wire signed [11:0] rcrit_e = {remote_critical_limit[7], remote_critical_limit, 3'h0};
    wire signed [8:0] hyst_s = {1'b0, critical_hysteresis};
    wire signed [8:0] rcrit_rel = {remote_critical_limit[7], remote_critical_limit} - hyst_s;
    wire signed [11:0] rcrit_rel_e = {rcrit_rel, 3'h0};
    wire signed [8:0] lcrit_rel = {local_critical_limit[7], local_critical_limit} - hyst_s;
    wire signed [11:0] rem_val_w = {rem_val[10], rem_val};
    wire signed [8:0] local_w = {local_sat[7], local_sat};

    wire [2:0] rem_cond;
    assign rem_cond[0] = rem_val > rhigh_e;
    assign rem_cond[1] = rem_val < rlow_e;
    assign rem_cond[2] = rem_val_w > rcrit_e;

    // fault queue: one run counter per remote limit
    logic [1:0] fq_cnt_reg [3];
    logic [2:0] rem_trip;

    generate
        for (gi = 0; gi < 3; gi++) begin : g_fq
            wire [1:0] cnt_next = !rem_cond[gi] ? 2'h0 :
                (fq_cnt_reg[gi] == tsr_pkg::FQ_DEPTH) ? tsr_pkg::FQ_DEPTH :
                fq_cnt_reg[gi] + 2'h1;
            always_ff @(posedge clk_sys_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    fq_cnt_reg[gi] <= 2'h0;
                end else if (conv_done) begin
                    fq_cnt_reg[gi] <= cnt_next;
                end
            end
            assign rem_trip[gi] = fq_on ? (cnt_next == tsr_pkg::FQ_DEPTH) : rem_cond[gi];
        end
    endgenerate

    // measurement registers and status
    logic [7:0] status_reg;
    logic signed [7:0] local_temp_reg;
    logic [7:0] remote_int_reg;
    logic [7:0] remote_frac_reg;
    logic [7:0] frac_snap_reg;
    logic frac_lock_reg;

    // critical flags release only once the reading falls to limit minus hysteresis
    wire rcrit_next = rem_trip[2] | (status_reg[tsr_pkg::ST_RCRIT] & (rem_val_w > rcrit_rel_e));
    wire lcrit_next = (local_sat > local_critical_limit) |
        (status_reg[tsr_pkg::ST_LCRIT] & (local_w > lcrit_rel));

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            status_reg <= tsr_pkg::RST_STATUS;
            local_temp_reg <= 8'sh00;
            remote_int_reg <= 8'h00;
            remote_frac_reg <= 8'h00;
        end else if (conv_done) begin
            local_temp_reg <= local_sat;
            remote_int_reg <= rem_val[10:3];
            remote_frac_reg <= {rem_val[2:0], 5'h00};
            status_reg <= {1'b0, local_sat > local_high_limit, local_sat < local_low_limit,
                rem_trip[0], rem_trip[1], meas_i.diode_open, rcrit_next, lcrit_next};
        end else if (conv_start) begin
            status_reg[tsr_pkg::ST_BUSY] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            frac_snap_reg <= 8'h00;
            frac_lock_reg <= 1'b0;
        end else if (ev_rd && pointer_reg == tsr_pkg::ADDR_REMOTE_INT) begin
            frac_snap_reg <= remote_frac_reg;
            frac_lock_reg <= 1'b1;
        end else if (ev_rd && pointer_reg == tsr_pkg::ADDR_REMOTE_FRAC) begin
            frac_lock_reg <= 1'b0;
        end
    end

    assign alarm_status_o = status_reg;

    // read selection; one-shot and unassigned locations fall through to zero
    wire [7:0] frac_view = frac_lock_reg ? frac_snap_reg : remote_frac_reg;
    wire [7:0] rd_fixed = (pointer_reg == tsr_pkg::ADDR_LOCAL_TEMP) ? local_temp_reg :
        (pointer_reg == tsr_pkg::ADDR_REMOTE_INT) ? remote_int_reg :
        (pointer_reg == tsr_pkg::ADDR_STATUS) ? status_reg :
        (pointer_reg == tsr_pkg::ADDR_REMOTE_FRAC) ? frac_view :
        (pointer_reg == tsr_pkg::ADDR_MAKER) ? MAKER_ID :
        (pointer_reg == tsr_pkg::ADDR_REVISION) ? DIE_REV : 8'h00;
    wire [7:0] rd_mux = rd_fixed | set_rd_chain[tsr_pkg::NUM_SET];

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sys_rd_data_reg <= 8'h00;
            sys_ack_tgl_reg <= 1'b0;
        end else if (req_ev) begin
            if (ev_rd) begin
                sys_rd_data_reg <= rd_mux;
            end
            sys_ack_tgl_reg <= ~sys_ack_tgl_reg;
        end
    end

endmodule

`default_nettype wire

// ### tb/tsr_sva.sv
// port checker for the sensor register file
// assumes: bound onto tsr_register_file, names match its ports
`timescale 1ns/1ps
`default_nettype none
module tsr_sva (
    // clocks and reset
    input wire logic clk_sys_i,
    input wire logic clk_link_i,
    input wire logic resetn_i,
    // link side
    input wire logic lk_req_valid_i,
    input wire tsr_pkg::tsr_req_t lk_req_i,
    input wire logic lk_ready_o,
    input wire logic lk_rd_valid_o,
    input wire logic [7:0] lk_rd_data_o,
    // measurement side
    input wire logic meas_valid_i,
    input wire tsr_pkg::tsr_meas_t meas_i,
    input wire logic conv_req_o,
    input wire logic [7:0] alarm_status_o
);
    sequence s_take;
        lk_req_valid_i && lk_ready_o;
    endsequence
    chk_take_busy: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
        s_take |=> !lk_ready_o) else $error("ready kept");
    chk_answer_bound: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
        $fell(lk_ready_o) |-> ##[1:16] lk_ready_o) else $error("no answer");
    chk_read_ready: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
        lk_rd_valid_o |-> lk_ready_o) else $error("read while busy");
    chk_read_pulse: assert property (@(posedge clk_link_i) disable iff (!resetn_i)
        lk_rd_valid_o |=> !lk_rd_valid_o) else $error("read strobe long");
    chk_conv_pulse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        conv_req_o |=> !conv_req_o) else $error("start long");
    chk_busy_start: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        conv_req_o |-> alarm_status_o[7]) else $error("busy low");
    chk_busy_end: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        meas_valid_i && alarm_status_o[7] |=> !alarm_status_o[7]) else $error("busy kept");
    chk_status_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !(meas_valid_i && alarm_status_o[7]) |=> $stable(alarm_status_o[6:0]))
        else $error("status moved");
endmodule
`default_nettype wire

// ### tb/tsr_meas_model.sv
// measurement path stand-in: one result per conversion start
// assumes: the bench sets the value before starting a conversion
`timescale 1ns/1ps
`default_nettype none
module tsr_meas_model #(parameter int DLY = 4) (
    // control
    input wire logic clk_i,
    input wire logic conv_i,
    input wire tsr_pkg::tsr_meas_t val_i,
    // result
    output logic valid_o,
    output tsr_pkg::tsr_meas_t meas_o
);
    int cnt = 0;
    initial begin
        valid_o = 0;
        meas_o = '0;
    end
    // bus toggles outside the strobe so a stale value is never read as valid
    always @(negedge clk_i) begin
        valid_o <= (cnt == 1);
        meas_o <= (cnt == 1) ? val_i : ~meas_o;
        cnt <= conv_i ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule
`default_nettype wire

// ### tb/temp_sensor_register_file_tb_top.sv
// bench for the sensor register file: map, defaults, one-shot readings
// assumes: the stand-in answers each conversion start
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_file_tb_top;
    logic clk_sys_i = 0, clk_link_i = 0, resetn_i = 0, lk_req_valid_i = 0;
    logic lk_ready_o, lk_rd_valid_o, conv_req_o, meas_valid_i;
    logic [7:0] lk_rd_data_o, alarm_status_o, rd, d;
    logic [7:0] fq[$];
    logic [31:0] seed = 32'hE02C7876;
    tsr_pkg::tsr_req_t lk_req_i = '0;
    tsr_pkg::tsr_meas_t meas_i, mv = '0;
    int bad_count = 0, total_checks = 0, cyc = 0, nconv = 0, n0, r;
    initial forever #20 clk_sys_i = ~clk_sys_i;
    initial begin
        #3;
        forever #7.5 clk_link_i = ~clk_link_i;
    end
    // identity values arbitrary; short base period keeps run mode busy
    tsr_register_file #(.CONV_BASE_CYCLES(5120), .MAKER_ID(8'h3C), .DIE_REV(8'hC3)) uut (.*);
    tsr_meas_model pm (.clk_i(clk_sys_i), .conv_i(conv_req_o), .val_i(mv),
        .valid_o(meas_valid_i), .meas_o(meas_i));
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic req(input logic [1:0] k, input logic [7:0] v);
        int n;
        n = 0;
        @(negedge clk_link_i);
        lk_req_valid_i = 1;
        lk_req_i.kind = tsr_pkg::tsr_req_kind_t'(k);
        lk_req_i.data = v;
        do @(posedge clk_link_i); while (!lk_ready_o);
        @(negedge clk_link_i);
        lk_req_valid_i = 0;
        do begin
            @(posedge clk_link_i);
            n++;
        end while (!lk_ready_o && n < 40);
        chk({lk_ready_o, lk_rd_valid_o}, {1'b1, k == 2'h2});
        rd = lk_rd_data_o;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req(0, a);
        req(1, v);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        req(0, a);
        req(2, 8'h00);
        chk(rd, e);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (conv_req_o === 1'b1) nconv++;
        if (cyc == 30000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        #170 resetn_i = 1;
        req(2, 8'h00);
        chk(rd, 8'h00);
        for (int i = 0; i < tsr_pkg::NUM_SET; i++)
            rdchk(tsr_pkg::SET_RD_ADDR[i], tsr_pkg::SET_RESET[i]);
        $display("defaults done");
        for (int i = 0; i < tsr_pkg::NUM_SET; i++) begin
            d = rnd();
            wr(tsr_pkg::SET_WR_ADDR[i], d);
            if (i < 6) wr(tsr_pkg::SET_RD_ADDR[i], ~d);
            rdchk(tsr_pkg::SET_RD_ADDR[i], d & tsr_pkg::SET_MASK[i]);
        end
        rdchk(8'h0F, 8'h00);
        rdchk(8'hFE, 8'h3C);
        rdchk(8'hFF, 8'hC3);
        $display("map done");
        wr(8'h09, 8'h40);
        wr(8'hBF, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h12, 8'h00);
        repeat (50) @(posedge clk_sys_i);
        for (int i = 0; i < 2; i++) begin
            d = rnd();
            mv.local_raw = i ? 10'h12C : {d[7], d[7], d};
            mv.remote_raw = i ? 12'h7F8 : {d[7], d[7], d[7], d[7], d};
            r = i ? 1023 : $signed(d);
            n0 = nconv;
            wr(8'h0F, rnd());
            repeat (20) @(posedge clk_sys_i);
            chk(8'(nconv - n0), 8'h01);
            rdchk(8'h00, i ? 8'h7F : d);
            if (i == 1) rdchk(8'h10, fq.pop_front());
            rdchk(8'h01, 8'(r >>> 3));
            fq.push_back(8'((r & 7) << 5));
        end
        rdchk(8'h10, fq.pop_front());
        $display("conversions done");
        wr(8'h09, 8'h41);
        wr(8'h0D, 8'h00);
        for (int j = 0; j < 4; j++) begin
            mv.remote_raw = j ? 12'h7F8 : 12'h000;
            wr(8'h0F, 8'h00);
            repeat (20) @(posedge clk_sys_i);
            chk(alarm_status_o[4], j == 3);
        end
        // level 2 from a settled 127.875 reading toward 20.625
        wr(8'hBF, 8'h06);
        mv.remote_raw = 12'h0A5;
        for (int j = 0; j < 40; j++) begin
            wr(8'h0F, 8'h00);
            repeat (20) @(posedge clk_sys_i);
            if (j == 0) rdchk(8'h01, 8'h65);
        end
        rdchk(8'h01, 8'h14);
        rdchk(8'h10, 8'hA0);
        $display("queue and filter done");
        end_sim();
    end
endmodule
bind tsr_register_file tsr_sva chk (.*);
`default_nettype wire
